//--- hdl/escmd_core.sv
// Purpose: Command interpreter and status reporting for the encoder parameter channel.
// Assumes: Frame = bus address, command, arguments, XOR checksum; end marked by i_rx_end.
// Notes: Replies are address, command, data, checksum; errors set bit 7 of the command.
//
// Functional notes
// - Status zero when no fault detected.
// - Distinct codes for each initialization failure but alignment, whose 0x01 is shared with analog.
// - Supervision restart reported with its code.
// - Parity, frame checksum, unknown command codes.
// - Wrong byte count, disallowed argument codes.
// - Write-protected field and wrong key codes.
// - Fixed size, address overrun, missing field.
// - Speed, singleturn, three multiturn position codes.
// - Analog signals out of specification reported.
// - Transmitter current, temperature, counter overflow codes.
// - Data-field command byte set.
// - Housekeeping command byte set.
// - Protected commands checked against key byte.

`timescale 1ns/10ps

module escmd_core #(
    parameter logic [7:0] TYPE_ID = 8'h3c, // Arbitrary value.
    parameter logic [15:0] SERIAL_NO = 16'h1234, // Arbitrary value.
    parameter logic [15:0] FW_VER = 16'h0100, // Arbitrary value.
    parameter logic [3:0] WP_MASK = 4'h1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_valid,
    input wire logic i_rx_perr,
    input wire logic i_rx_end,
    output logic [7:0] o_tx_byte,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic [escmd_pkg::POS_BITS-1:0] i_position,
    input wire logic [7:0] i_temp,
    input wire logic i_flt_align,
    input wire logic i_flt_offset,
    input wire logic i_flt_part,
    input wire logic i_flt_alim,
    input wire logic i_flt_twi,
    input wire logic i_flt_int_chk,
    input wire logic i_flt_wdog,
    input wire logic i_flt_analog,
    input wire logic i_flt_speed,
    input wire logic i_flt_st_pos,
    input wire logic [2:0] i_flt_mt_pos,
    input wire logic i_flt_tx_cur,
    input wire logic i_flt_temp,
    output logic [7:0] o_status,
    output logic [7:0] o_bus_addr,
    output logic [7:0] o_mode,
    output logic [15:0] o_counter,
    output logic o_pos_set,
    output logic [escmd_pkg::POS_BITS-1:0] o_pos_value,
    output logic o_dev_reset
);

    // ==========================================================
    // State
    typedef enum logic [1:0] {S_RX, S_EXEC, S_MEMRD, S_TX} escmd_state_t;

    typedef struct packed {
        escmd_state_t state;
        logic [7:0][7:0] rx_buf;
        logic [3:0] rx_cnt;
        logic [7:0] rx_xor;
        logic rx_perr;
        logic rx_ovf;
        logic [7:0] bus_addr;
        logic [7:0] mode;
        logic [7:0] key;
        logic [15:0] counter;
        logic [7:0] status;
        logic [7:0][7:0] tx_buf;
        logic [3:0] tx_len;
        logic [3:0] tx_idx;
        logic pos_set;
        logic [escmd_pkg::POS_BITS-1:0] pos_val;
        logic dev_rst;
    } escmd_regs_t;

    escmd_regs_t r_r;
    escmd_regs_t r_nxt;
    logic mem_we;
    logic mem_re;
    logic [escmd_pkg::MEM_AW-1:0] mem_addr;
    logic [7:0] mem_q;

    // ==========================================================
    // Command table: {known, argument count, keyed, key position}.
    function automatic logic [7:0] cmd_info(input logic [7:0] c);
        case (c)
            escmd_pkg::CMD_POS_RD: cmd_info = 8'h80;
            escmd_pkg::CMD_POS_SET: cmd_info = 8'hd8;
            escmd_pkg::CMD_ANA_RD: cmd_info = 8'h90;
            escmd_pkg::CMD_CNT_RD: cmd_info = 8'h80;
            escmd_pkg::CMD_CNT_INC: cmd_info = 8'h80;
            escmd_pkg::CMD_CNT_CLR: cmd_info = 8'h98;
            escmd_pkg::CMD_DAT_RD: cmd_info = 8'ha0;
            escmd_pkg::CMD_DAT_WR: cmd_info = 8'hca;
            escmd_pkg::CMD_FLD_STAT: cmd_info = 8'h90;
            escmd_pkg::CMD_FLD_NEW: cmd_info = 8'hba;
            escmd_pkg::CMD_MEM_FREE: cmd_info = 8'h80;
            escmd_pkg::CMD_KEY_CHG: cmd_info = 8'ha8;
            escmd_pkg::CMD_STAT_RD: cmd_info = 8'h80;
            escmd_pkg::CMD_TYPE_RD: cmd_info = 8'h80;
            escmd_pkg::CMD_DEV_RST: cmd_info = 8'h80;
            escmd_pkg::CMD_ADR_SET: cmd_info = 8'ha8;
            escmd_pkg::CMD_SER_RD: cmd_info = 8'h80;
            escmd_pkg::CMD_IF_CFG: cmd_info = 8'ha8;
            default: cmd_info = 8'h00;
        endcase
    endfunction

    // Reply frame with trailing XOR checksum; length is data count plus three.
    function automatic logic [7:0][7:0] build(input logic [7:0] a, input logic [7:0] c,
                                              input logic [3:0][7:0] d, input logic [2:0] dl);
        logic [7:0][7:0] b;
        logic [7:0] x;
        b = '0;
        b[0] = a;
        b[1] = c;
        x = a ^ c;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < dl) begin
                b[2+i] = d[i];
                x = x ^ d[i];
            end
        end
        b[3'(dl) + 3'd2] = x;
        build = b;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] cmd;
        logic [7:0] info;
        logic [3:0] na;
        logic [7:0] ec;
        logic [2:0] dl;
        logic [3:0][7:0] d;
        logic evt;
        logic [7:0] evt_code;
        r_nxt = r_r;
        cmd = r_r.rx_buf[1];
        info = cmd_info(cmd);
        na = r_r.rx_cnt - escmd_pkg::FRAME_OVH;
        ec = escmd_pkg::ST_OK;
        dl = 3'd0;
        d = '0;
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_addr = 7'({r_r.rx_buf[2][1:0], r_r.rx_buf[3][4:0]});
        r_nxt.pos_set = 1'b0;
        r_nxt.dev_rst = 1'b0;
        unique case (r_r.state)
            S_RX: begin
                if (i_rx_end) begin
                    r_nxt.state = S_EXEC;
                end else if (i_rx_valid) begin
                    if (r_r.rx_cnt < escmd_pkg::RX_MAX) begin
                        r_nxt.rx_buf[r_r.rx_cnt[2:0]] = i_rx_byte;
                        r_nxt.rx_cnt = r_r.rx_cnt + 4'd1;
                    end else begin
                        r_nxt.rx_ovf = 1'b1;
                    end
                    r_nxt.rx_xor = r_r.rx_xor ^ i_rx_byte;
                    r_nxt.rx_perr = r_r.rx_perr | i_rx_perr;
                end
            end
            S_EXEC: begin
                r_nxt.state = S_TX;
                r_nxt.tx_idx = 4'd0;
                if (r_r.rx_cnt < escmd_pkg::FRAME_OVH || r_r.rx_buf[0] != r_r.bus_addr) begin
                    r_nxt.state = S_RX;
                end else if (r_r.rx_perr) begin
                    ec = escmd_pkg::ST_PARITY;
                end else if (r_r.rx_xor != 8'h00) begin
                    ec = escmd_pkg::ST_RX_CHK;
                end else if (!info[7]) begin
                    ec = escmd_pkg::ST_UNK_CMD;
                end else if (r_r.rx_ovf || na != {1'b0, info[6:4]}) begin
                    ec = escmd_pkg::ST_LEN;
                end else if (info[3] && r_r.rx_buf[2 + info[2:0]] != r_r.key) begin
                    ec = escmd_pkg::ST_KEY;
                end else begin
                    case (cmd)
                        escmd_pkg::CMD_POS_RD: begin
                            d = 32'(i_position);
                            d = {d[0], d[1], d[2], d[3]};
                            dl = 3'd4;
                        end
                        escmd_pkg::CMD_POS_SET: begin
                            r_nxt.pos_val = 27'({r_r.rx_buf[3], r_r.rx_buf[4],
                                                 r_r.rx_buf[5], r_r.rx_buf[6]});
                            r_nxt.pos_set = 1'b1;
                        end
                        escmd_pkg::CMD_ANA_RD: begin
                            if (r_r.rx_buf[2] == escmd_pkg::ANA_TEMP_CH) begin
                                d[0] = r_r.rx_buf[2];
                                d[1] = i_temp;
                                dl = 3'd2;
                            end else begin
                                ec = escmd_pkg::ST_ARG;
                            end
                        end
                        escmd_pkg::CMD_CNT_RD: begin
                            d[0] = r_r.counter[15:8];
                            d[1] = r_r.counter[7:0];
                            dl = 3'd2;
                        end
                        escmd_pkg::CMD_CNT_INC: begin
                            if (&r_r.counter) begin
                                ec = escmd_pkg::ST_CNT_OVF;
                            end else begin
                                r_nxt.counter = r_r.counter + 16'd1;
                            end
                        end
                        escmd_pkg::CMD_CNT_CLR: r_nxt.counter = escmd_pkg::RST_COUNTER;
                        escmd_pkg::CMD_DAT_RD, escmd_pkg::CMD_DAT_WR,
                        escmd_pkg::CMD_FLD_STAT, escmd_pkg::CMD_FLD_NEW: begin
                            if (r_r.rx_buf[2] >= escmd_pkg::NUM_FIELDS) begin
                                ec = escmd_pkg::ST_NOFIELD;
                            end else if (cmd == escmd_pkg::CMD_FLD_STAT) begin
                                d[0] = {WP_MASK[r_r.rx_buf[2][1:0]],
                                        escmd_pkg::FIELD_BYTES[6:0]};
                                dl = 3'd1;
                            end else if (cmd == escmd_pkg::CMD_FLD_NEW) begin
                                if (r_r.rx_buf[3] != escmd_pkg::FIELD_BYTES) begin
                                    ec = escmd_pkg::ST_FIXSIZE;
                                end
                            end else if (r_r.rx_buf[3] >= escmd_pkg::FIELD_BYTES) begin
                                ec = escmd_pkg::ST_WADDR;
                            end else if (cmd == escmd_pkg::CMD_DAT_RD) begin
                                mem_re = 1'b1;
                                r_nxt.state = S_MEMRD;
                            end else if (WP_MASK[r_r.rx_buf[2][1:0]]) begin
                                ec = escmd_pkg::ST_WPROT;
                            end else begin
                                mem_we = 1'b1;
                            end
                        end
                        escmd_pkg::CMD_MEM_FREE: dl = 3'd1;
                        escmd_pkg::CMD_KEY_CHG: r_nxt.key = r_r.rx_buf[3];
                        escmd_pkg::CMD_STAT_RD: begin
                            d[0] = r_r.status;
                            dl = 3'd1;
                            r_nxt.status = escmd_pkg::ST_OK;
                        end
                        escmd_pkg::CMD_TYPE_RD: begin
                            d[0] = TYPE_ID;
                            dl = 3'd1;
                        end
                        escmd_pkg::CMD_DEV_RST: begin
                            r_nxt.dev_rst = 1'b1;
                            r_nxt.status = escmd_pkg::ST_OK;
                        end
                        escmd_pkg::CMD_ADR_SET: r_nxt.bus_addr = r_r.rx_buf[3];
                        escmd_pkg::CMD_SER_RD: begin
                            d = {FW_VER[7:0], FW_VER[15:8], SERIAL_NO[7:0], SERIAL_NO[15:8]};
                            dl = 3'd4;
                        end
                        escmd_pkg::CMD_IF_CFG: r_nxt.mode = r_r.rx_buf[3];
                        default: ec = escmd_pkg::ST_UNK_CMD;
                    endcase
                end
                if (ec != escmd_pkg::ST_OK) begin
                    d[0] = ec;
                    r_nxt.tx_buf = build(r_r.rx_buf[0], cmd | escmd_pkg::ERR_FLAG, d, 3'd1);
                    r_nxt.tx_len = 4'd4;
                    r_nxt.status = ec;
                end else begin
                    r_nxt.tx_buf = build(r_r.rx_buf[0], cmd, d, dl);
                    r_nxt.tx_len = 4'({1'b0, dl}) + escmd_pkg::FRAME_OVH;
                end
            end
            S_MEMRD: begin
                d[0] = mem_q;
                r_nxt.tx_buf = build(r_r.rx_buf[0], cmd, d, 3'd1);
                r_nxt.tx_len = 4'd4;
                r_nxt.state = S_TX;
            end
            S_TX: begin
                if (i_tx_ready) begin
                    r_nxt.tx_idx = r_r.tx_idx + 4'd1;
                    if (r_r.tx_idx == r_r.tx_len - 4'd1) begin
                        r_nxt.state = S_RX;
                    end
                end
            end
        endcase
        if (r_nxt.state == S_RX && r_r.state != S_RX) begin
            r_nxt.rx_cnt = 4'd0;
            r_nxt.rx_xor = 8'h00;
            r_nxt.rx_perr = 1'b0;
            r_nxt.rx_ovf = 1'b0;
        end
        // Fault events are applied last so that they win over a clear by read.
        evt = 1'b1;
        evt_code = escmd_pkg::ST_OK;
        if (i_flt_align) evt_code = escmd_pkg::ST_ALIGN;
        else if (i_flt_offset) evt_code = escmd_pkg::ST_OFFSET;
        else if (i_flt_part) evt_code = escmd_pkg::ST_PART;
        else if (i_flt_alim) evt_code = escmd_pkg::ST_ALIM;
        else if (i_flt_twi) evt_code = escmd_pkg::ST_TWI;
        else if (i_flt_int_chk) evt_code = escmd_pkg::ST_INT_CHK;
        else if (i_flt_wdog) evt_code = escmd_pkg::ST_WDOG;
        else if (i_flt_analog) evt_code = escmd_pkg::ST_ANALOG;
        else if (i_flt_speed) evt_code = escmd_pkg::ST_SPEED;
        else if (i_flt_st_pos) evt_code = escmd_pkg::ST_ST_POS;
        else if (i_flt_mt_pos[0]) evt_code = escmd_pkg::ST_MT_POS;
        else if (i_flt_mt_pos[1]) evt_code = escmd_pkg::ST_MT_POS + 8'h01;
        else if (i_flt_mt_pos[2]) evt_code = escmd_pkg::ST_MT_POS + 8'h02;
        else if (i_flt_tx_cur) evt_code = escmd_pkg::ST_TX_CUR;
        else if (i_flt_temp) evt_code = escmd_pkg::ST_TEMP;
        else evt = 1'b0;
        if (evt) begin
            r_nxt.status = evt_code;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            r_r <= '0;
            r_r.state <= S_RX;
            r_r.status <= escmd_pkg::ST_OK;
            r_r.bus_addr <= escmd_pkg::RST_BUS_ADDR;
            r_r.mode <= escmd_pkg::RST_MODE;
            r_r.counter <= escmd_pkg::RST_COUNTER;
            r_r.key <= escmd_pkg::RST_KEY;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ==========================================================
    // Data-field memory and outputs
    escmd_mem #(.DW(8), .AW(escmd_pkg::MEM_AW)) u_mem (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(mem_we),
        .i_re(mem_re),
        .i_addr(mem_addr),
        .i_wdata(r_r.rx_buf[5]),
        .o_rdata(mem_q)
    );

    assign o_tx_valid = (r_r.state == S_TX);
    assign o_tx_byte = r_r.tx_buf[r_r.tx_idx[2:0]];
    assign o_status = r_r.status;
    assign o_bus_addr = r_r.bus_addr;
    assign o_mode = r_r.mode;
    assign o_counter = r_r.counter;
    assign o_pos_set = r_r.pos_set;
    assign o_pos_value = r_r.pos_val;
    assign o_dev_reset = r_r.dev_rst;

endmodule

//--- common/escmd_pkg.sv
// Purpose: Shared constants for the encoder serial command handler.
// Assumes: Byte-wide receive and transmit paths from an external character layer.
// Notes: Status codes, command bytes and delivery values live here only.

package escmd_pkg;

    // ==========================================================
    // Status codes
    localparam logic [7:0]
        ST_OK = 8'h00,
        ST_ALIGN = 8'h01,
        ST_OFFSET = 8'h02,
        ST_PART = 8'h03,
        ST_ALIM = 8'h04,
        ST_TWI = 8'h05,
        ST_INT_CHK = 8'h06,
        ST_WDOG = 8'h07,
        ST_CNT_OVF = 8'h08,
        ST_PARITY = 8'h09,
        ST_RX_CHK = 8'h0a,
        ST_UNK_CMD = 8'h0b,
        ST_LEN = 8'h0c,
        ST_ARG = 8'h0d,
        ST_WPROT = 8'h0e,
        ST_KEY = 8'h0f,
        ST_FIXSIZE = 8'h10,
        ST_WADDR = 8'h11,
        ST_NOFIELD = 8'h12,
        ST_ANALOG = 8'h01,
        ST_TX_CUR = 8'h1d,
        ST_TEMP = 8'h1e,
        ST_SPEED = 8'h1f,
        ST_ST_POS = 8'h20,
        ST_MT_POS = 8'h21;

    // ==========================================================
    // Command bytes
    localparam logic [7:0]
        CMD_POS_RD = 8'h42,
        CMD_POS_SET = 8'h43,
        CMD_ANA_RD = 8'h44,
        CMD_CNT_RD = 8'h46,
        CMD_CNT_INC = 8'h47,
        CMD_CNT_CLR = 8'h49,
        CMD_DAT_RD = 8'h4a,
        CMD_DAT_WR = 8'h4b,
        CMD_FLD_STAT = 8'h4c,
        CMD_FLD_NEW = 8'h4d,
        CMD_MEM_FREE = 8'h4e,
        CMD_KEY_CHG = 8'h4f,
        CMD_STAT_RD = 8'h50,
        CMD_TYPE_RD = 8'h52,
        CMD_DEV_RST = 8'h53,
        CMD_ADR_SET = 8'h55,
        CMD_SER_RD = 8'h56,
        CMD_IF_CFG = 8'h57;

    // ==========================================================
    // Delivery values, layout and sizes
    localparam logic [7:0]
        RST_BUS_ADDR = 8'h40,
        RST_MODE = 8'he4,
        RST_KEY = 8'h55,
        ANA_TEMP_CH = 8'h48,
        ERR_FLAG = 8'h80,
        NUM_FIELDS = 8'h04,
        FIELD_BYTES = 8'h20;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [3:0] RX_MAX = 4'h8, FRAME_OVH = 4'h3;
    localparam int POS_BITS = 27, MEM_AW = 7;

endpackage

//--- hdl/escmd_mem.sv
// Purpose: Data-field byte memory with registered read data.
// Assumes: One access per cycle; write and read never issued together.
// Notes: Array contents are not reset; only the read register is.

`timescale 1ns/10ps

module escmd_mem #(
    parameter int DW = 8,
    parameter int AW = 7
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end

endmodule

//--- tb/escmd_core_sva.sv
// Purpose: Concurrent checks on the ports of the command handler core.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the core.

`timescale 1ns/10ps

module escmd_core_sva (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_rx_end,
    input wire logic i_tx_ready,
    input wire logic i_flt_align,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_byte,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_bus_addr,
    input wire logic [7:0] o_mode,
    input wire logic [15:0] o_counter,
    input wire logic o_pos_set,
    input wire logic o_dev_reset
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ==========================================================
    // Reset and status
    property p_rst_cfg;
        $fell(i_sys_rst) |-> o_bus_addr == 8'h40 && o_mode == 8'he4 && o_counter == 16'h0000;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg)
        else $error("bad delivery settings");
    property p_rst_idle;
        $fell(i_sys_rst) |-> o_status == 8'h00 && !o_tx_valid && !o_pos_set && !o_dev_reset;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("not idle after reset");
    property p_align;
        i_flt_align |=> o_status == 8'h01;
    endproperty
    a_align: assert property (p_align)
        else $error("align code missing");
    property p_cnt;
        $changed(o_counter) |-> o_counter == $past(o_counter) + 16'h0001 || o_counter == 16'h0000;
    endproperty
    a_cnt: assert property (p_cnt)
        else $error("bad counter step");

    // ==========================================================
    // Reply handshake and pulses
    property p_hold;
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte);
    endproperty
    a_hold: assert property (p_hold)
        else $error("reply byte dropped");
    property p_lat;
        $rose(o_tx_valid) |-> $past(i_rx_end, 2) || $past(i_rx_end, 3);
    endproperty
    a_lat: assert property (p_lat)
        else $error("bad reply latency");
    property p_pos;
        o_pos_set |=> !o_pos_set;
    endproperty
    a_pos: assert property (p_pos)
        else $error("pos pulse too long");
    property p_dev;
        o_dev_reset |=> !o_dev_reset;
    endproperty
    a_dev: assert property (p_dev)
        else $error("reset pulse too long");
endmodule

bind escmd_core escmd_core_sva escmd_core_sva_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rx_end(i_rx_end),
    .i_tx_ready(i_tx_ready), .i_flt_align(i_flt_align), .o_tx_valid(o_tx_valid),
    .o_tx_byte(o_tx_byte), .o_status(o_status), .o_bus_addr(o_bus_addr), .o_mode(o_mode),
    .o_counter(o_counter), .o_pos_set(o_pos_set), .o_dev_reset(o_dev_reset));

//--- tb/escmd_drive.sv
// Purpose: Behavioural drive controller sending frames and taking replies.
// Assumes: One frame at a time; the bench picks the flaw.
// Notes: A slow controller takes one reply byte every four cycles.

`timescale 1ns/10ps

module escmd_drive (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_rx_perr,
    output logic o_rx_end,
    output logic o_tx_ready
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    logic [1:0] tick = 2'h0;

    assign o_tx_ready = !slow || tick == 2'h3;
    always @(posedge i_ref_clk) begin
        tick <= tick + 2'h1;
        if (i_tx_valid && o_tx_ready) got.push_back(i_tx_byte);
    end
    initial begin
        o_rx_byte = 8'h00;
        o_rx_valid = 1'b0;
        o_rx_perr = 1'b0;
        o_rx_end = 1'b0;
    end

    // ==========================================================
    // Frame sender
    // Released data lines show the inverse so stale bytes are never mistaken.
    task automatic send(input logic [63:0] f, input int n, input logic [1:0] flaw);
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        got.delete();
        for (int k = 0; k <= n; k++) begin
            b = (k < n) ? f[8*(n-1-k) +: 8] : c ^ {7'h00, flaw[0]};
            c = c ^ b;
            @(posedge i_ref_clk);
            #1;
            o_rx_byte = b;
            o_rx_valid = 1'b1;
            o_rx_perr = flaw[1] && k == 1;
        end
        @(posedge i_ref_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_perr = 1'b0;
        o_rx_byte = ~o_rx_byte;
        @(posedge i_ref_clk);
        #1;
        o_rx_end = 1'b1;
        @(posedge i_ref_clk);
        #1;
        o_rx_end = 1'b0;
    endtask
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the encoder serial command handler.
// Assumes: Drive controller model sends one frame at a time.
// Notes: Counter overflow needs 65536 frames and is not run here.

`timescale 1ns/10ps

module tb_top;
    localparam logic [7:0] TYPE_ID = 8'h5a; // Arbitrary value.
    localparam logic [15:0] SERIAL_NO = 16'h2468; // Arbitrary value.
    localparam logic [15:0] FW_VER = 16'h0203; // Arbitrary value.
    // Expected status codes in fault port order.
    localparam logic [119:0] FC = 120'h01020304050607011f202122231d1e;
    logic clk, rst, rx_valid, rx_perr, rx_end, tx_valid, tx_ready, pos_set, dev_rst;
    logic [7:0] rx_byte, tx_byte, temp, status, bus_addr, mode;
    logic [15:0] counter;
    logic [14:0] flt;
    logic [26:0] pos, pos_val;
    logic [26:0] pos_seen = 27'h0;
    logic rst_seen = 1'b0;
    logic [1:0] flaw = 2'h0;
    int fail_count = 0;
    int num_checks = 0;

    escmd_core #(.TYPE_ID(TYPE_ID), .SERIAL_NO(SERIAL_NO), .FW_VER(FW_VER)) escmd_core_i (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_rx_byte(rx_byte), .i_rx_valid(rx_valid),
        .i_rx_perr(rx_perr), .i_rx_end(rx_end), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .i_position(pos), .i_temp(temp), .i_flt_align(flt[0]),
        .i_flt_offset(flt[1]), .i_flt_part(flt[2]), .i_flt_alim(flt[3]), .i_flt_twi(flt[4]),
        .i_flt_int_chk(flt[5]), .i_flt_wdog(flt[6]), .i_flt_analog(flt[7]),
        .i_flt_speed(flt[8]), .i_flt_st_pos(flt[9]), .i_flt_mt_pos(flt[12:10]),
        .i_flt_tx_cur(flt[13]), .i_flt_temp(flt[14]), .o_status(status),
        .o_bus_addr(bus_addr), .o_mode(mode), .o_counter(counter), .o_pos_set(pos_set),
        .o_pos_value(pos_val), .o_dev_reset(dev_rst));
    escmd_drive escmd_drive_i (
        .i_ref_clk(clk), .i_tx_byte(tx_byte), .i_tx_valid(tx_valid), .o_rx_byte(rx_byte),
        .o_rx_valid(rx_valid), .o_rx_perr(rx_perr), .o_rx_end(rx_end), .o_tx_ready(tx_ready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pos_set) pos_seen <= pos_val;
        if (dev_rst) rst_seen <= 1'b1;
    end

    // ==========================================================
    // Checking helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Sends nf frame bytes and expects nr reply bytes plus their checksum.
    task automatic x(input logic [63:0] f, input int nf, input logic [63:0] r, input int nr);
        logic [63:0] v;
        logic [7:0] c;
        v = 64'h0;
        c = 8'h00;
        escmd_drive_i.send(f, nf, flaw);
        for (int i = 0; i < 200 && escmd_drive_i.got.size() < nr + 1; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        foreach (escmd_drive_i.got[i]) v = {v[55:0], escmd_drive_i.got[i]};
        for (int i = 0; i < nr; i++) c = c ^ r[8*i +: 8];
        chk(64'(escmd_drive_i.got.size()), 64'(nr + 1));
        chk(v, {r[55:0], c});
    endtask
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_faults();
        chk({status, bus_addr, mode, counter}, 40'h0040e40000);
        x(64'h4052, 2, {16'h4052, TYPE_ID}, 3);
        for (int k = 0; k < 15; k++) begin
            flt = 15'h0001 << k;
            @(posedge clk);
            #1;
            flt = 15'h0000;
            @(posedge clk);
            #1;
            chk(status, FC[8*(14-k) +: 8]);
            x(64'h4050, 2, {16'h4050, FC[8*(14-k) +: 8]}, 3);
            chk(status, 8'h00);
        end
    endtask
    task automatic t_errors();
        x(64'h4041, 2, 64'h40c10b, 3);
        flaw = 2'h2;
        x(64'h4050, 2, 64'h40d009, 3);
        flaw = 2'h1;
        x(64'h4050, 2, 64'h40d00a, 3);
        flaw = 2'h0;
        x(64'h405000, 3, 64'h40d00c, 3);
        x(64'h404400, 3, 64'h40c40d, 3);
        x(64'h404900, 3, 64'h40c90f, 3);
        x(64'h404b00055511, 6, 64'h40cb0e, 3);
        x(64'h404d011055, 5, 64'h40cd10, 3);
        x(64'h404a0120, 4, 64'h40ca11, 3);
        x(64'h404a0400, 4, 64'h40ca12, 3);
    endtask
    task automatic t_data();
        escmd_drive_i.slow = 1'b1;
        x(64'h4042, 2, 64'h404205abcdef, 6);
        x(64'h40435501234567, 7, 64'h4043, 2);
        chk(pos_seen, 27'h1234567);
        x(64'h404448, 3, 64'h4044483b, 4);
        x(64'h4047, 2, 64'h4047, 2);
        x(64'h4047, 2, 64'h4047, 2);
        x(64'h4046, 2, 64'h40460002, 4);
        x(64'h404955, 3, 64'h4049, 2);
        chk(counter, 16'h0000);
        x(64'h404b010555a7, 6, 64'h404b, 2);
        x(64'h404a0105, 4, 64'h404aa7, 3);
        escmd_drive_i.slow = 1'b0;
        x(64'h404c01, 3, 64'h404c20, 3);
        x(64'h404e, 2, 64'h404e00, 3);
    endtask
    task automatic t_house();
        x(64'h404f5566, 4, 64'h404f, 2);
        x(64'h404955, 3, 64'h40c90f, 3);
        x(64'h4050, 2, 64'h40500f, 3);
        x(64'h404f6655, 4, 64'h404f, 2);
        x(64'h4056, 2, {16'h4056, SERIAL_NO, FW_VER}, 6);
        x(64'h405755e5, 4, 64'h4057, 2);
        chk(mode, 8'he5);
        x(64'h40555541, 4, 64'h4055, 2);
        chk(bus_addr, 8'h41);
        x(64'h4153, 2, 64'h4153, 2);
        chk(rst_seen, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        flt = 15'h0000;
        pos = 27'h5abcdef;
        temp = 8'h3b;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_faults();
        t_errors();
        t_data();
        t_house();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule
